// [rtl/bwc_pkg.sv]
// constants and types for the bus window control/status logic
package bwc_pkg;

    // register index on the plain register port
    localparam int          ADDR_W         = 3;
    localparam logic [2:0]  OFF_CSR_A      = 3'h0;
    localparam logic [2:0]  OFF_CSR_B      = 3'h1;
    localparam logic [2:0]  OFF_INT_STAT   = 3'h2;
    localparam logic [2:0]  OFF_INT_MASK   = 3'h3;

    localparam int          DATA_W         = 16;
    localparam int          NPORT          = 2;

    // field positions of window_control_status
    localparam int          BIT_ERR        = 15;
    localparam int          BIT_TMO        = 14;
    localparam int          BIT_PWR        = 13;
    localparam int          BIT_ATTN       = 12;
    localparam int          BIT_IE         = 6;
    localparam int          BIT_TE         = 4;
    localparam int          BIT_WE         = 1;
    localparam int          BIT_ND         = 0;

    // implemented bits; the rest read as zero
    localparam logic [15:0] CSR_IMPL_MASK  = 16'hf053;
    localparam logic [15:0] CSR_RST        = 16'h0000;
    localparam logic [1:0]  INT_STAT_RST   = 2'h0;
    localparam logic [1:0]  INT_MASK_RST   = 2'h0;
    localparam logic [15:0] RDATA_RST      = 16'h0000;

    // originator activity seen on one bus
    typedef struct packed {
        logic start;    // window transaction begins
        logic write;    // write, byte write or read-pause then write
        logic read;     // read or read-pause
        logic timeout;  // slave-sync timeout while mastering far bus
        logic aclo;     // power low on this bus
        logic attn;     // attention event, sets bit 12
        logic nd_clr;   // far side took the new data
    } bwc_evt_s;

    localparam bwc_evt_s    EVT_RST        = '0;

endpackage : bwc_pkg

// [rtl/bwc_window_csr.sv]
// control/status and error logic of both ports of a two-bus window
//
// Overview of operation
// - interrupt when bit 15 or bit 12 set, enable bit 6 set and the port's bit in the interrupt mask register set
// - write-zero-only bits read fully; writing one leaves them alone
// - new data bit 0 set by writing one; writing zero changes nothing
// - bus initialize clears every control/status bit
// - error when originator starts while far transfer enable clear
// - error on write cycle while far write enable clear
// - slave-sync timeout on far bus sets error and bit 14
// - far power low sets error and bit 13; cleared by power return
// - simultaneous reads from both buses set the error bit
// - software writes zero to bit 15 to clear the error, except while bit 13 is set
// - while error set, transactions from that bus get no answer
`timescale 1ns/1ns
`default_nettype none

module bwc_window_csr
(
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic                          bus_init,
    input  wire bwc_pkg::bwc_evt_s             evt_a,
    input  wire bwc_pkg::bwc_evt_s             evt_b,
    input  wire logic [bwc_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [bwc_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [bwc_pkg::DATA_W-1:0]    reg_rdata,
    output logic                               irq,
    output logic                               pass_a,
    output logic                               pass_b
);

    // synchronisers and edge history
    bwc_pkg::bwc_evt_s           ev_s1_reg [bwc_pkg::NPORT];
    bwc_pkg::bwc_evt_s           ev_s2_reg [bwc_pkg::NPORT];
    bwc_pkg::bwc_evt_s           ev_d_reg  [bwc_pkg::NPORT];
    logic                        init_s1_reg;
    logic                        init_s2_reg;

    logic [15:0]                 csr_reg   [bwc_pkg::NPORT];
    logic [15:0]                 csr_next  [bwc_pkg::NPORT];
    logic [1:0]                  int_stat_reg;
    logic [1:0]                  int_stat_next;
    logic [1:0]                  int_mask_reg;
    logic [15:0]                 rdata_reg;
    logic                        irq_reg;
    logic [1:0]                  pass_reg;
    logic [1:0]                  pass_next;

    logic [1:0]                  start_p;
    logic [1:0]                  tmo_p;
    logic [1:0]                  attn_p;
    logic [1:0]                  ndclr_p;
    logic [1:0]                  rd_lv;
    logic [1:0]                  wr_lv;
    logic [1:0]                  aclo_lv;
    logic [1:0]                  aclo_fall;
    logic [1:0]                  viol;
    logic [1:0]                  cause;
    logic [1:0]                  csr_wr;

    // pin inputs pass two flip-flops before use
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            for (int s = 0; s < bwc_pkg::NPORT; s++)
            begin
                ev_s1_reg[s] <= bwc_pkg::EVT_RST;
                ev_s2_reg[s] <= bwc_pkg::EVT_RST;
                ev_d_reg[s]  <= bwc_pkg::EVT_RST;
            end
            init_s1_reg <= 1'b0;
            init_s2_reg <= 1'b0;
        end
        else
        begin
            ev_s1_reg[0] <= evt_a;
            ev_s1_reg[1] <= evt_b;
            for (int s = 0; s < bwc_pkg::NPORT; s++)
            begin
                ev_s2_reg[s] <= ev_s1_reg[s];
                ev_d_reg[s]  <= ev_s2_reg[s];
            end
            init_s1_reg <= bus_init;
            init_s2_reg <= init_s1_reg;
        end
    end

    // per-port event decode
    always_comb
    begin
        for (int s = 0; s < bwc_pkg::NPORT; s++)
        begin
            start_p[s]   = ev_s2_reg[s].start & ~ev_d_reg[s].start;
            tmo_p[s]     = ev_s2_reg[s].timeout & ~ev_d_reg[s].timeout;
            attn_p[s]    = ev_s2_reg[s].attn & ~ev_d_reg[s].attn;
            ndclr_p[s]   = ev_s2_reg[s].nd_clr & ~ev_d_reg[s].nd_clr;
            rd_lv[s]     = ev_s2_reg[s].read;
            wr_lv[s]     = ev_s2_reg[s].write;
            aclo_lv[s]   = ev_s2_reg[s].aclo;
            aclo_fall[s] = ev_d_reg[s].aclo & ~ev_s2_reg[s].aclo;
        end
        csr_wr[0] = reg_wr && (reg_addr == bwc_pkg::OFF_CSR_A);
        csr_wr[1] = reg_wr && (reg_addr == bwc_pkg::OFF_CSR_B);
    end

    // illegal access, charged to the originating port
    always_comb
    begin
        for (int s = 0; s < bwc_pkg::NPORT; s++)
        begin
            viol[s] = (start_p[s] & ~csr_reg[1-s][bwc_pkg::BIT_TE])
                    | (start_p[s] & wr_lv[s]
                       & ~csr_reg[1-s][bwc_pkg::BIT_WE])
                    | tmo_p[s]
                    | aclo_lv[1-s]
                    | (start_p[s] & rd_lv[s]
                       & start_p[1-s] & rd_lv[1-s]);
        end
    end

    // next value of each port register
    always_comb
    begin
        for (int s = 0; s < bwc_pkg::NPORT; s++)
        begin
            csr_next[s] = csr_reg[s];
            if (ndclr_p[s])
                csr_next[s][bwc_pkg::BIT_ND] = 1'b0;
            if (csr_wr[s])
            begin
                csr_next[s][bwc_pkg::BIT_IE] = reg_wdata[bwc_pkg::BIT_IE];
                csr_next[s][bwc_pkg::BIT_TE] = reg_wdata[bwc_pkg::BIT_TE];
                csr_next[s][bwc_pkg::BIT_WE] = reg_wdata[bwc_pkg::BIT_WE];
                if (reg_wdata[bwc_pkg::BIT_ND])
                    csr_next[s][bwc_pkg::BIT_ND] = 1'b1;
                if (!reg_wdata[bwc_pkg::BIT_ERR]
                    && !csr_reg[s][bwc_pkg::BIT_PWR])
                    csr_next[s][bwc_pkg::BIT_ERR] = 1'b0;
                if (!reg_wdata[bwc_pkg::BIT_TMO])
                    csr_next[s][bwc_pkg::BIT_TMO] = 1'b0;
                if (!reg_wdata[bwc_pkg::BIT_ATTN])
                    csr_next[s][bwc_pkg::BIT_ATTN] = 1'b0;
            end
            // power back on the far bus ends the power error
            if (aclo_fall[1-s])
            begin
                csr_next[s][bwc_pkg::BIT_PWR] = 1'b0;
                csr_next[s][bwc_pkg::BIT_ERR] = 1'b0;
            end
            // hardware sets win over software clears
            if (viol[s])
                csr_next[s][bwc_pkg::BIT_ERR] = 1'b1;
            if (tmo_p[s])
                csr_next[s][bwc_pkg::BIT_TMO] = 1'b1;
            if (aclo_lv[1-s])
                csr_next[s][bwc_pkg::BIT_PWR] = 1'b1;
            if (attn_p[s])
                csr_next[s][bwc_pkg::BIT_ATTN] = 1'b1;
            csr_next[s] = csr_next[s] & bwc_pkg::CSR_IMPL_MASK;
            if (init_s2_reg)
                csr_next[s] = bwc_pkg::CSR_RST;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            csr_reg[0] <= bwc_pkg::CSR_RST;
            csr_reg[1] <= bwc_pkg::CSR_RST;
        end
        else
        begin
            csr_reg[0] <= csr_next[0];
            csr_reg[1] <= csr_next[1];
        end
    end

    // forward a transaction only while the port is free of error
    always_comb
    begin
        for (int s = 0; s < bwc_pkg::NPORT; s++)
            pass_next[s] = start_p[s] & ~viol[s]
                         & ~csr_reg[s][bwc_pkg::BIT_ERR];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pass_reg <= 2'h0;
        else
            pass_reg <= pass_next;
    end

    // interrupt causes, sticky status, write one to clear
    always_comb
    begin
        for (int s = 0; s < bwc_pkg::NPORT; s++)
            cause[s] = (csr_reg[s][bwc_pkg::BIT_ERR]
                        | csr_reg[s][bwc_pkg::BIT_ATTN])
                     & csr_reg[s][bwc_pkg::BIT_IE];
        int_stat_next = int_stat_reg;
        if (reg_wr && (reg_addr == bwc_pkg::OFF_INT_STAT))
            int_stat_next = int_stat_reg & ~reg_wdata[1:0];
        int_stat_next = int_stat_next | cause;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            int_stat_reg <= bwc_pkg::INT_STAT_RST;
            int_mask_reg <= bwc_pkg::INT_MASK_RST;
            irq_reg      <= 1'b0;
        end
        else
        begin
            int_stat_reg <= int_stat_next;
            if (reg_wr && (reg_addr == bwc_pkg::OFF_INT_MASK))
                int_mask_reg <= reg_wdata[1:0];
            irq_reg <= |(int_stat_reg & int_mask_reg);
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rdata_reg <= bwc_pkg::RDATA_RST;
        else if (reg_rd)
        begin
            case (reg_addr)
                bwc_pkg::OFF_CSR_A:    rdata_reg <= csr_reg[0];
                bwc_pkg::OFF_CSR_B:    rdata_reg <= csr_reg[1];
                bwc_pkg::OFF_INT_STAT: rdata_reg <= {14'h0000, int_stat_reg};
                bwc_pkg::OFF_INT_MASK: rdata_reg <= {14'h0000, int_mask_reg};
                default:               rdata_reg <= bwc_pkg::RDATA_RST;
            endcase
        end
        else
            rdata_reg <= bwc_pkg::RDATA_RST;
    end

    assign reg_rdata = rdata_reg;
    assign irq       = irq_reg;
    assign pass_a    = pass_reg[0];
    assign pass_b    = pass_reg[1];

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_dual_read;
        start_p[0] && rd_lv[0] && start_p[1] && rd_lv[1];
    endsequence

    sequence s_both_flagged;
        csr_reg[0][bwc_pkg::BIT_ERR] && csr_reg[1][bwc_pkg::BIT_ERR];
    endsequence

    chk_irq_cause: assert property (
        (csr_reg[0][bwc_pkg::BIT_ERR] && csr_reg[0][bwc_pkg::BIT_IE]
         && int_mask_reg[0]) |-> ##2 irq)
        else $error("error with enable did not raise irq");

    chk_w0_hold: assert property (
        (csr_wr[0] && reg_wdata[bwc_pkg::BIT_TMO] && !tmo_p[0]
         && !init_s2_reg)
        |=> (csr_reg[0][bwc_pkg::BIT_TMO]
             == $past(csr_reg[0][bwc_pkg::BIT_TMO])))
        else $error("writing one changed a clear-only bit");

    chk_nd_set: assert property (
        (csr_wr[0] && !init_s2_reg
         && reg_wdata[bwc_pkg::BIT_ND] == !csr_reg[0][bwc_pkg::BIT_ND]
         && !ndclr_p[0])
        |=> csr_reg[0][bwc_pkg::BIT_ND])
        else $error("new data bit wrong after write");

    chk_init_clear: assert property (
        init_s2_reg |=> (csr_reg[0] == 16'h0000 && csr_reg[1] == 16'h0000))
        else $error("bus initialize left bits set");

    chk_te_error: assert property (
        (start_p[0] && !csr_reg[1][bwc_pkg::BIT_TE] && !init_s2_reg)
        |=> (csr_reg[0][bwc_pkg::BIT_ERR] && !pass_a))
        else $error("start without far transfer enable not flagged");

    chk_we_error: assert property (
        (start_p[1] && wr_lv[1] && !csr_reg[0][bwc_pkg::BIT_WE]
         && !init_s2_reg) |=> csr_reg[1][bwc_pkg::BIT_ERR])
        else $error("write without far write enable not flagged");

    chk_tmo_flags: assert property (
        (tmo_p[0] && !init_s2_reg)
        |=> (csr_reg[0][bwc_pkg::BIT_ERR] && csr_reg[0][bwc_pkg::BIT_TMO]))
        else $error("timeout did not set error and bit 14");

    chk_aclo_hold: assert property (
        (aclo_lv[1] && !init_s2_reg)
        |=> (csr_reg[0][bwc_pkg::BIT_PWR] && csr_reg[0][bwc_pkg::BIT_ERR]))
        else $error("far power low not held in error");

    chk_dual_read: assert property (
        (s_dual_read and !init_s2_reg) |=> s_both_flagged)
        else $error("simultaneous reads not flagged");

    chk_err_clear: assert property (
        (csr_wr[0] && !reg_wdata[bwc_pkg::BIT_ERR] && !viol[0]
         && !csr_reg[0][bwc_pkg::BIT_PWR] && !aclo_lv[1])
        |=> !csr_reg[0][bwc_pkg::BIT_ERR])
        else $error("writing zero did not clear error");

    chk_block_pass: assert property (
        (csr_reg[0][bwc_pkg::BIT_ERR] && start_p[0]) |=> !pass_a)
        else $error("transaction passed while error set");

    chk_own_port: assert property (
        (viol[0] && !viol[1] && !csr_wr[1] && !init_s2_reg
         && !aclo_fall[0])
        |=> $stable(csr_reg[1][bwc_pkg::BIT_ERR]))
        else $error("error charged to the wrong port");

endmodule : bwc_window_csr

`default_nettype wire

// [sim/bwc_orig_model.sv]
// originator model driving both buses of the window
`timescale 1ns/1ns
`default_nettype none

module bwc_orig_model
(
    input  wire logic             mclk,
    output var bwc_pkg::bwc_evt_s evt_a,
    output var bwc_pkg::bwc_evt_s evt_b
);
    initial
    begin
        evt_a = bwc_pkg::EVT_RST;
        evt_b = bwc_pkg::EVT_RST;
    end

    // cycle type and aclo held after start drops; edges stay at least 7 low cycles apart
    task automatic drive(input logic to_a, input logic to_b,
                         input bwc_pkg::bwc_evt_s e);
        @(posedge mclk);
        if (to_a)
            evt_a <= e;
        if (to_b)
            evt_b <= e;
        repeat (3) @(posedge mclk);
        e.start   = 1'b0;
        e.timeout = 1'b0;
        e.attn    = 1'b0;
        e.nd_clr  = 1'b0;
        if (to_a)
            evt_a <= e;
        if (to_b)
            evt_b <= e;
        repeat (6) @(posedge mclk);
    endtask : drive

endmodule : bwc_orig_model

`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the bus window control/status logic
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam logic [2:0] CA  = bwc_pkg::OFF_CSR_A;
    localparam logic [2:0] CB  = bwc_pkg::OFF_CSR_B;
    localparam logic [2:0] IS  = bwc_pkg::OFF_INT_STAT;
    localparam logic [2:0] IM  = bwc_pkg::OFF_INT_MASK;
    // event bits: start write read timeout aclo attn nd_clr
    localparam logic [6:0] RD  = 7'h50;
    localparam logic [6:0] WRT = 7'h60;
    localparam logic [6:0] TMO = 7'h08;
    localparam logic [6:0] PWR = 7'h04;
    localparam logic [6:0] ATN = 7'h02;
    localparam logic [6:0] NDC = 7'h01;

    logic                        mclk;
    logic                        rst_n;
    logic                        bus_init;
    bwc_pkg::bwc_evt_s           evt_a;
    bwc_pkg::bwc_evt_s           evt_b;
    logic [bwc_pkg::ADDR_W-1:0]  reg_addr;
    logic [15:0]                 reg_wdata;
    logic                        reg_wr;
    logic                        reg_rd;
    logic [15:0]                 reg_rdata;
    logic                        irq;
    logic                        pass_a;
    logic                        pass_b;
    int                          miscompares;
    int                          checked;
    int                          cyc;
    int                          na;
    int                          nb;
    int                          pa0;
    int                          pb0;

    bwc_window_csr DUT (.mclk(mclk), .rst_n(rst_n), .bus_init(bus_init),
        .evt_a(evt_a), .evt_b(evt_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .pass_a(pass_a), .pass_b(pass_b));
    bwc_orig_model orig (.mclk(mclk), .evt_a(evt_a), .evt_b(evt_b));

    always #5 mclk = ~mclk;

    // pass pulses counted off the edge; cycle ceiling cuts a hang
    always @(negedge mclk)
    begin
        cyc++;
        if (pass_a === 1'b1)
            na++;
        if (pass_b === 1'b1)
            nb++;
        if (cyc == 5000)
        begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        chk($sformatf("reg %h", a), exp, reg_rdata);
        @(posedge mclk);
    endtask : rchk

    task automatic go(input logic to_a, input logic to_b,
                      input logic [6:0] v);
        pa0 = na;
        pb0 = nb;
        orig.drive(to_a, to_b, bwc_pkg::bwc_evt_s'(v));
    endtask : go

    task automatic pchk(input int ea, input int eb);
        chk("pass_a count", 16'(ea), 16'(na - pa0));
        chk("pass_b count", 16'(eb), 16'(nb - pb0));
    endtask : pchk

    task automatic ichk(input logic exp);
        @(negedge mclk);
        chk("irq", {15'h0000, exp}, {15'h0000, irq});
        @(posedge mclk);
    endtask : ichk

    task automatic t_reset;
        for (int a = 0; a < 8; a++)
            rchk(a[2:0], 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_enable;
        go(1'b1, 1'b0, RD);
        pchk(0, 0);
        rchk(CA, 16'h8000);
        rchk(CB, 16'h0000);
        wr(CB, 16'h0012);
        go(1'b1, 1'b0, RD);
        pchk(0, 0);
        wr(CA, 16'h0012);
        rchk(CA, 16'h0012);
        wr(CA, 16'h8012);
        rchk(CA, 16'h0012);
        go(1'b1, 1'b0, RD);
        pchk(1, 0);
        go(1'b1, 1'b0, WRT);
        pchk(1, 0);
        go(1'b0, 1'b1, WRT);
        pchk(0, 1);
        wr(CB, 16'h0010);
        go(1'b1, 1'b0, WRT);
        pchk(0, 0);
        rchk(CA, 16'h8012);
        wr(CA, 16'h0010);
        go(1'b0, 1'b1, WRT);
        pchk(0, 0);
        rchk(CB, 16'h8010);
        wr(CA, 16'h0012);
        wr(CB, 16'h0012);
        $display("test enables done");
    endtask : t_enable

    task automatic t_faults;
        go(1'b1, 1'b0, TMO);
        rchk(CA, 16'hc012);
        wr(CA, 16'hc012);
        rchk(CA, 16'hc012);
        rchk(CB, 16'h0012);
        wr(CA, 16'h0012);
        rchk(CA, 16'h0012);
        go(1'b0, 1'b1, PWR);
        rchk(CA, 16'ha012);
        wr(CA, 16'h0012);
        rchk(CA, 16'ha012);
        go(1'b0, 1'b1, 7'h00);
        rchk(CA, 16'h0012);
        go(1'b1, 1'b1, RD);
        pchk(0, 0);
        rchk(CA, 16'h8012);
        rchk(CB, 16'h8012);
        wr(CA, 16'h0012);
        wr(CB, 16'h0012);
        $display("test faults done");
    endtask : t_faults

    task automatic t_irq;
        wr(CA, 16'h0052);
        go(1'b1, 1'b0, TMO);
        rchk(IS, 16'h0001);
        ichk(1'b0);
        wr(IM, 16'h0001);
        ichk(1'b1);
        wr(CA, 16'h0052);
        wr(IS, 16'h0001);
        rchk(IS, 16'h0000);
        ichk(1'b0);
        go(1'b1, 1'b0, ATN);
        rchk(CA, 16'h1052);
        ichk(1'b1);
        wr(CA, 16'h0012);
        wr(IS, 16'h0001);
        go(1'b1, 1'b0, TMO);
        rchk(IS, 16'h0000);
        wr(CA, 16'h0012);
        $display("test interrupt done");
    endtask : t_irq

    task automatic t_init;
        wr(CA, 16'h0013);
        rchk(CA, 16'h0013);
        wr(CA, 16'h0012);
        rchk(CA, 16'h0013);
        go(1'b1, 1'b0, NDC);
        rchk(CA, 16'h0012);
        bus_init <= 1'b1;
        repeat (3) @(posedge mclk);
        bus_init <= 1'b0;
        repeat (3) @(posedge mclk);
        rchk(CA, 16'h0000);
        rchk(CB, 16'h0000);
        $display("test init done");
    endtask : t_init

    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        bus_init = 1'b0;
        reg_addr = '0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_enable();
        t_faults();
        t_irq();
        t_init();
        close_out();
    end

endmodule : tb

`default_nettype wire
